/* File: adc_regs_pkg.sv */
package adc_regs_pkg;

    // Widths
    localparam int DATA_W  = 24;
    localparam int STAT_W  = 8;
    localparam int SHIFT_W = 32;
    localparam int CNT_W   = 6;
    localparam int CHAN_W  = 3;

    // Register-select codes
    localparam logic [2:0] RS_COMM_STATUS = 3'h0;
    localparam logic [2:0] RS_MODE        = 3'h1;
    localparam logic [2:0] RS_CONFIG      = 3'h2;
    localparam logic [2:0] RS_DATA        = 3'h3;
    localparam logic [2:0] RS_ID          = 3'h4;
    localparam logic [2:0] RS_GPO         = 3'h5;

    // Reset values and writable bits of the mode register
    localparam logic [STAT_W-1:0] STATUS_RESET = 8'h80;
    localparam logic [DATA_W-1:0] MODE_RESET   = 24'h080060;
    localparam logic [DATA_W-1:0] MODE_WMASK   = 24'hfcbfff;
    localparam logic [DATA_W-1:0] ALL_ONES     = 24'hffffff;

    // Mode register fields
    localparam int MD_OP_HI   = 23;
    localparam int MD_OP_LO   = 21;
    localparam int MD_APPEND  = 20;
    localparam int MD_ODD_CHK = 13;

    // Command byte fields
    localparam logic [CNT_W-1:0] CMD_BITS = 6'h08;
    localparam int CMD_RW    = 6;
    localparam int CMD_RS_HI = 5;
    localparam int CMD_RS_LO = 3;

    // Transfer lengths in bits
    localparam logic [CNT_W-1:0] LEN_8  = 6'h08;
    localparam logic [CNT_W-1:0] LEN_24 = 6'h18;
    localparam logic [CNT_W-1:0] LEN_32 = 6'h20;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

    typedef enum logic [1:0] {S_CMD, S_WRITE, S_READ} link_e;

endpackage

/* File: adc_status_mode_registers.sv */
`timescale 1ns/1ps
module adc_status_mode_registers
    import adc_regs_pkg::*;
#(
    parameter logic [2:0] IDLE_MODE_CODE  = 3'h4,
    parameter logic [2:0] PDOWN_MODE_CODE = 3'h2
) (
    input  wire logic                             CLK,
    input  wire logic                             RST,
    input  wire logic                             SCLK,
    input  wire logic                             CS_N,
    input  wire logic                             DIN,
    input  wire logic                             SYNC_N,
    output logic                                  DOUT_RDY_N,
    output logic                                  DOUT_OE,
    input  wire logic                             RESULT_VALID,
    input  wire logic [adc_regs_pkg::DATA_W-1:0]  RESULT,
    input  wire logic                             RESULT_CLAMPED,
    input  wire logic [adc_regs_pkg::CHAN_W-1:0]  RESULT_CHANNEL,
    input  wire logic                             UPDATE_AHEAD,
    input  wire logic                             VREF_LOW,
    input  wire logic                             VREF_DETECT_ENABLE,
    output logic      [adc_regs_pkg::DATA_W-1:0]  OPERATING_SETUP,
    output logic                                  FILTER_RESTART
);
    import adc_regs_pkg::*;

    typedef struct packed {
        link_e                st;
        logic [SHIFT_W-1:0]   shift;
        logic [CNT_W-1:0]     cnt;
        logic [2:0]           rs;
        logic                 due;
        logic                 rdy;
        logic                 err;
        logic                 missing_vref_flag;
        logic                 parity;
        logic [CHAN_W-1:0]    source_channel_tag;
        logic [DATA_W-1:0]    operating_setup;
        logic [DATA_W-1:0]    data;
        logic                 restart;
        logic                 dout;
        logic                 oe;
    } regs_s;

    localparam regs_s RESET_STATE = '{
        st:                 S_CMD,
        shift:              '0,
        cnt:                '0,
        rs:                 RS_COMM_STATUS,
        due:                1'b0,
        rdy:                STATUS_RESET[7],
        err:                STATUS_RESET[6],
        missing_vref_flag:  STATUS_RESET[5],
        parity:             STATUS_RESET[4],
        source_channel_tag: STATUS_RESET[2:0],
        operating_setup:    MODE_RESET,
        data:               '0,
        restart:            1'b0,
        dout:               STATUS_RESET[7],
        oe:                 1'b0
    };

    regs_s cur;
    regs_s next_cur;

    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_n_s;
    logic       din_s;
    logic       sync_n_s;
    logic       low_power;
    logic [STAT_W-1:0] status_now;

    pin_sampler #(
        .W (4)
    ) u_pins (
        .clk   (CLK),
        .rst   (RST),
        .pins  ({SYNC_N, DIN, CS_N, SCLK}),
        .level (pin_level),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    assign sclk_rise = pin_rise[0];
    assign sclk_fall = pin_fall[0];
    assign cs_n_s    = pin_level[1];
    assign din_s     = pin_level[2];
    assign sync_n_s  = pin_level[3];

    function automatic logic [STAT_W-1:0] status_word(input regs_s r);
        status_word = {r.rdy, r.err, r.missing_vref_flag, r.parity, 1'b0,
                       r.source_channel_tag};
    endfunction

    function automatic logic [CNT_W-1:0] reg_bits(input logic [2:0] rs, input logic app);
        case (rs)
            RS_COMM_STATUS, RS_ID, RS_GPO: reg_bits = LEN_8;
            RS_DATA:                       reg_bits = app ? LEN_32 : LEN_24;
            default:                       reg_bits = LEN_24;
        endcase
    endfunction

    // Read image, left-aligned so that bit 31 leaves first
    function automatic logic [SHIFT_W-1:0] read_image(input regs_s r, input logic [2:0] rs);
        case (rs)
            RS_COMM_STATUS: read_image = {status_word(r), 24'h000000};
            RS_MODE:        read_image = {r.operating_setup, 8'h00};
            RS_DATA:        read_image = {r.data, status_word(r)};
            default:        read_image = '0;
        endcase
    endfunction

    assign status_now = status_word(cur);

    assign low_power = (cur.operating_setup[MD_OP_HI:MD_OP_LO] == IDLE_MODE_CODE)
                    || (cur.operating_setup[MD_OP_HI:MD_OP_LO] == PDOWN_MODE_CODE);

    always_comb
    begin
        logic              read_done;
        logic              missing_vref_flag_now;
        logic              set_rdy;
        logic [DATA_W-1:0] stored;
        read_done = 1'b0;
        missing_vref_flag_now = VREF_DETECT_ENABLE & VREF_LOW;
        set_rdy   = 1'b0;
        stored    = RESULT;
        next_cur  = cur;
        next_cur.restart = 1'b0;
        if (cs_n_s)
        begin
            next_cur.st  = S_CMD;
            next_cur.cnt = '0;
            next_cur.due = 1'b0;
        end
        else
        begin
            case (cur.st)
                S_CMD:
                begin
                    // Leading one is ignored until a zero arrives
                    if (sclk_rise && !(cur.cnt == '0 && din_s))
                    begin
                        next_cur.shift = {cur.shift[SHIFT_W-2:0], din_s};
                        next_cur.cnt   = cur.cnt + CNT_ONE;
                        if (cur.cnt == CMD_BITS - CNT_ONE)
                        begin
                            next_cur.rs  = next_cur.shift[CMD_RS_HI:CMD_RS_LO];
                            next_cur.cnt = reg_bits(next_cur.rs,
                                                    cur.operating_setup[MD_APPEND]);
                            if (next_cur.shift[CMD_RW])
                            begin
                                next_cur.st    = S_READ;
                                next_cur.shift = read_image(cur, next_cur.rs);
                                next_cur.due   = 1'b0;
                            end
                            else if (next_cur.rs == RS_COMM_STATUS)
                            begin
                                next_cur.cnt = '0;
                            end
                            else
                            begin
                                next_cur.st = S_WRITE;
                            end
                        end
                    end
                end
                S_WRITE:
                begin
                    if (sclk_rise)
                    begin
                        next_cur.shift = {cur.shift[SHIFT_W-2:0], din_s};
                        next_cur.cnt   = cur.cnt - CNT_ONE;
                        if (cur.cnt == CNT_ONE)
                        begin
                            next_cur.st  = S_CMD;
                            next_cur.cnt = '0;
                            if (cur.rs == RS_MODE)
                            begin
                                next_cur.operating_setup =
                                    next_cur.shift[DATA_W-1:0] & MODE_WMASK;
                                next_cur.restart = 1'b1;
                            end
                        end
                    end
                end
                S_READ:
                begin
                    if (sclk_rise)
                    begin
                        next_cur.cnt = cur.cnt - CNT_ONE;
                        next_cur.due = 1'b1;
                        if (cur.cnt == CNT_ONE)
                        begin
                            next_cur.st  = S_CMD;
                            next_cur.cnt = '0;
                            next_cur.due = 1'b0;
                            read_done    = (cur.rs == RS_DATA);
                        end
                    end
                    else if (sclk_fall && cur.due)
                    begin
                        next_cur.shift = {cur.shift[SHIFT_W-2:0], 1'b0};
                        next_cur.due   = 1'b0;
                    end
                end
                default:
                begin
                    next_cur.st = S_CMD;
                end
            endcase
        end

        next_cur.missing_vref_flag = missing_vref_flag_now;
        if (RESULT_VALID)
        begin
            if (missing_vref_flag_now)
            begin
                stored = ALL_ONES;
            end
            next_cur.data               = stored;
            next_cur.rdy                = 1'b0;
            next_cur.err                = RESULT_CLAMPED | missing_vref_flag_now;
            next_cur.parity             = cur.operating_setup[MD_ODD_CHK] & (^stored);
            next_cur.source_channel_tag = RESULT_CHANNEL;
        end
        // Any set source outranks a concurrent clear
        set_rdy = UPDATE_AHEAD | read_done | next_cur.restart | low_power | !sync_n_s;
        if (set_rdy)
        begin
            next_cur.rdy = 1'b1;
        end
        next_cur.dout = (next_cur.st == S_READ) ? next_cur.shift[SHIFT_W-1]
                                                : next_cur.rdy;
        next_cur.oe   = !cs_n_s;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cur <= RESET_STATE;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign DOUT_RDY_N      = cur.dout;
    assign DOUT_OE         = cur.oe;
    assign OPERATING_SETUP = cur.operating_setup;
    assign FILTER_RESTART  = cur.restart;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    reset_values_a: assert property ($fell(RST) |->
        status_word(cur) == STATUS_RESET && cur.operating_setup == MODE_RESET)
        else $error("register reset values wrong");
    ready_clear_a: assert property (RESULT_VALID && !UPDATE_AHEAD && !low_power
        && sync_n_s && cur.st != S_READ && cur.st != S_WRITE |=> !cur.rdy)
        else $error("ready not cleared by new result");
    sync_ready_a: assert property (!sync_n_s |=> cur.rdy)
        else $error("ready not set while sync low");
    restart_ready_a: assert property (cur.restart |-> cur.rdy
        && (cur.operating_setup & ~MODE_WMASK) == '0)
        else $error("mode write left ready clear");
    error_flag_a: assert property (RESULT_VALID |=>
        cur.err == $past(RESULT_CLAMPED | (VREF_DETECT_ENABLE & VREF_LOW)))
        else $error("error flag mismatch");
    vref_clamp_a: assert property (RESULT_VALID && VREF_DETECT_ENABLE && VREF_LOW
        |=> cur.data == ALL_ONES && cur.missing_vref_flag)
        else $error("missing reference did not clamp");
    parity_flag_a: assert property (RESULT_VALID |=> cur.parity ==
        ($past(cur.operating_setup[MD_ODD_CHK]) & (^cur.data)))
        else $error("parity flag mismatch");
    channel_tag_a: assert property (RESULT_VALID |=>
        cur.source_channel_tag == $past(RESULT_CHANNEL))
        else $error("channel tag mismatch");
    bit3_zero_a: assert property (status_now[3] == 1'b0)
        else $error("status bit 3 not zero");
    dout_ready_a: assert property (cur.st != S_READ |-> DOUT_RDY_N == cur.rdy)
        else $error("data-out pin not showing ready");
    dout_msb_a: assert property (cur.st == S_READ |->
        DOUT_RDY_N == cur.shift[SHIFT_W-1])
        else $error("serial output not msb of shifter");
    append_len_a: assert property ($rose(cur.st == S_READ) && cur.rs == RS_DATA
        |-> cur.cnt == (cur.operating_setup[MD_APPEND] ? LEN_32 : LEN_24))
        else $error("data read length wrong");

    mode_write_c:  cover property (cur.restart);
    status_read_c: cover property ($rose(cur.st == S_READ) && cur.rs == RS_COMM_STATUS);
    data_append_c: cover property ($rose(cur.st == S_READ) && cur.cnt == LEN_32);
endmodule

/* File: host_model.sv */
`timescale 1ns/1ps
module host_model (
    input  wire logic CLK,
    output logic      SCLK,
    output logic      CS_N,
    output logic      DIN,
    input  wire logic DOUT_RDY_N
);
    // Phase length well above the three-cycle minimum of the sampler
    localparam int HALF = 6;

    // Clock stands high and data idles high outside frames
    initial
    begin
        SCLK = 1'b1;
        CS_N = 1'b1;
        DIN  = 1'b1;
    end

    // Drive on the fall, sample just before the rise
    task automatic bit_x(input logic b, output logic r);
        @(posedge CLK);
        #1;
        SCLK = 1'b0;
        DIN  = b;
        repeat (HALF) @(posedge CLK);
        #1;
        r    = DOUT_RDY_N;
        SCLK = 1'b1;
        repeat (HALF) @(posedge CLK);
    endtask

    task automatic frame(input logic rw, input logic [2:0] rs, input int n,
                         input logic [31:0] tx, output logic [31:0] rx);
        logic [7:0] cmd;
        logic       r;
        cmd = {1'b0, rw, rs, 3'h0};
        rx  = 32'h0;
        @(posedge CLK);
        #1;
        CS_N = 1'b0;
        repeat (HALF) @(posedge CLK);
        for (int i = 7; i >= 0; i--)
            bit_x(cmd[i], r);
        for (int i = n - 1; i >= 0; i--)
        begin
            bit_x(tx[i], r);
            rx = {rx[30:0], r};
        end
        repeat (HALF) @(posedge CLK);
        #1;
        CS_N = 1'b1;
        DIN  = 1'b1;
        repeat (HALF) @(posedge CLK);
    endtask
endmodule

/* File: pin_sampler.sv */
`timescale 1ns/1ps
module pin_sampler #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pins,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
        logic [W-1:0] stage3;
    } samp_s;

    samp_s cur;
    samp_s next_cur;

    always_comb
    begin
        next_cur        = cur;
        next_cur.stage1 = pins;
        next_cur.stage2 = cur.stage1;
        next_cur.stage3 = cur.stage2;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur <= '{default: '1};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // Edges judged only from the settled stages
    assign level = cur.stage2;
    assign rise  = cur.stage2 & ~cur.stage3;
    assign fall  = ~cur.stage2 & cur.stage3;
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module tb_top;
    import adc_regs_pkg::*;
    localparam logic [2:0] IDLE  = 3'h4;
    localparam logic [2:0] PDOWN = 3'h2;
    logic              CLK, RST, SCLK, CS_N, DIN, SYNC_N, DOUT_RDY_N, DOUT_OE;
    logic              RESULT_VALID, RESULT_CLAMPED, UPDATE_AHEAD, FILTER_RESTART;
    logic              VREF_LOW, VREF_DETECT_ENABLE;
    logic [DATA_W-1:0] RESULT, OPERATING_SETUP, d;
    logic [CHAN_W-1:0] RESULT_CHANNEL, ch;
    logic [31:0]       seed, rx;
    logic [7:0]        e;
    int                n_fail, tests_run, cycles, restarts;

    adc_status_mode_registers #(.IDLE_MODE_CODE(IDLE), .PDOWN_MODE_CODE(PDOWN))
    i_adc_status_mode_registers (
        .CLK(CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .SYNC_N(SYNC_N),
        .DOUT_RDY_N(DOUT_RDY_N), .DOUT_OE(DOUT_OE), .RESULT_VALID(RESULT_VALID),
        .RESULT(RESULT), .RESULT_CLAMPED(RESULT_CLAMPED), .RESULT_CHANNEL(RESULT_CHANNEL),
        .UPDATE_AHEAD(UPDATE_AHEAD), .VREF_LOW(VREF_LOW),
        .VREF_DETECT_ENABLE(VREF_DETECT_ENABLE), .OPERATING_SETUP(OPERATING_SETUP),
        .FILTER_RESTART(FILTER_RESTART)
    );
    host_model i_host_model (.CLK(CLK), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN),
                             .DOUT_RDY_N(DOUT_RDY_N));

    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    task automatic report_and_stop();
        $display("counts: run=%0d fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Restart pulses are counted; a hang is cut short
    always @(posedge CLK)
    begin
        cycles++;
        if (FILTER_RESTART === 1'b1)
            restarts++;
        if (cycles == 60000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] st(input logic rdy, err, nr, pe,
                                      input logic [23:0] v, input logic [2:0] c);
        return {rdy, err, nr, pe & (^v), 1'b0, c};
    endfunction

    task automatic store(input logic [23:0] v, input logic cl, input logic [2:0] c);
        @(posedge CLK);
        #1;
        RESULT_VALID   = 1'b1;
        RESULT         = v;
        RESULT_CLAMPED = cl;
        RESULT_CHANNEL = c;
        @(posedge CLK);
        #1;
        RESULT_VALID = 1'b0;
        RESULT       = ~v;
        repeat (3) @(posedge CLK);
    endtask

    task automatic rd(input logic [2:0] rs, input int n);
        i_host_model.frame(1'b1, rs, n, 32'h0, rx);
    endtask

    task automatic wr_mode(input logic [23:0] v);
        int r0;
        r0 = restarts;
        i_host_model.frame(1'b0, RS_MODE, 24, {8'h0, v}, rx);
        `CHK(restarts - r0, 1);
        `CHK(OPERATING_SETUP, v & MODE_WMASK);
    endtask

    initial
    begin
        {RST, SYNC_N} = 2'b11;
        {RESULT_VALID, RESULT_CLAMPED, UPDATE_AHEAD, VREF_LOW, VREF_DETECT_ENABLE} = 5'h00;
        RESULT = 24'h0;
        RESULT_CHANNEL = 3'h0;
        seed = 32'h17;
        repeat (20) @(posedge CLK);
        #1;
        RST = 1'b0;
        repeat (5) @(posedge CLK);
        `CHK(OPERATING_SETUP, MODE_RESET);
        `CHK(DOUT_RDY_N, 1'b1);
        `CHK(DOUT_OE, 1'b0);
        fork
            rd(RS_COMM_STATUS, 8);
            begin
                repeat (20) @(posedge CLK);
                #1;
                `CHK(DOUT_OE, 1'b1);
            end
        join
        `CHK(rx, STATUS_RESET);
        $display("test reset done");
        for (int i = 0; i < 2; i++)
        begin
            d = (i == 0) ? 24'h1fffff : {3'h0, 21'(xs())};
            wr_mode(d);
            rd(RS_MODE, 24);
            `CHK(rx, d & MODE_WMASK);
        end
        $display("test mode done");
        wr_mode(24'h102060);
        for (int i = 0; i < 6; i++)
        begin
            d  = (i == 0) ? 24'h0 : (i == 1) ? ALL_ONES : 24'(xs());
            ch = 3'(xs());
            store(d, i[0], ch);
            repeat (6) @(posedge CLK);
            `CHK(DOUT_RDY_N, 1'b0);
            rd(RS_COMM_STATUS, 8);
            e = st(1'b0, i[0], 1'b0, 1'b1, d, ch);
            `CHK(rx, e);
            rd(RS_DATA, 32);
            `CHK(rx, {d, e});
            rd(RS_COMM_STATUS, 8);
            `CHK(rx[7], 1'b1);
        end
        $display("test results done");
        #1;
        VREF_DETECT_ENABLE = 1'b1;
        VREF_LOW = 1'b1;
        store(24'(xs()), 1'b0, 3'h5);
        rd(RS_COMM_STATUS, 8);
        `CHK(rx, st(1'b0, 1'b1, 1'b1, 1'b1, ALL_ONES, 3'h5));
        rd(RS_DATA, 32);
        `CHK(rx[31:8], ALL_ONES);
        #1;
        VREF_LOW = 1'b0;
        rd(RS_COMM_STATUS, 8);
        `CHK(rx, st(1'b1, 1'b1, 1'b0, 1'b1, ALL_ONES, 3'h5));
        #1;
        VREF_DETECT_ENABLE = 1'b0;
        $display("test reference done");
        for (int k = 0; k < 5; k++)
        begin
            d = 24'(xs());
            store(d, 1'b0, 3'(xs()));
            #1;
            case (k)
                0: UPDATE_AHEAD = 1'b1;
                1: SYNC_N = 1'b0;
                2: wr_mode({IDLE, 21'h002060});
                3: wr_mode({PDOWN, 21'h002060});
                default: wr_mode(24'h102060);
            endcase
            // Low power must hold ready set even across a new result
            if (k == 2 || k == 3)
                store(d, 1'b0, 3'h1);
            repeat (4) @(posedge CLK);
            #1;
            UPDATE_AHEAD = 1'b0;
            rd(RS_COMM_STATUS, 8);
            `CHK(rx[7], 1'b1);
            if (k == 2)
            begin
                rd(RS_DATA, 24);
                `CHK(rx, d);
            end
            #1;
            SYNC_N = 1'b1;
            if (k > 1)
                wr_mode(24'h102060);
        end
        $display("test ready sources done");
        #1;
        RST = 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        RST = 1'b0;
        repeat (5) @(posedge CLK);
        `CHK(OPERATING_SETUP, MODE_RESET);
        `CHK(DOUT_OE, 1'b0);
        rd(RS_COMM_STATUS, 8);
        `CHK(rx, STATUS_RESET);
        $display("test reset again done");
        report_and_stop();
    end
endmodule
